// ---- rtl/nma_alu.sv ----
// Execution datapath for negative multiply-accumulate low halfword and the OR family.
// Assumes the decode stage presents an instruction with its three operand values in one cycle
// and consumes the registered write-back one cycle later without stalling.
// Notes on behaviour
// - Multiply low halfwords of both sources as signed values.
// - Negate product, add old target value into 33-bit sum.
// - Modulo form writes low 32 bits of the sum.
// - Saturating form without overflow writes low 32 bits unchanged.
// - Overflow when signs equal and sum sign differs; clamp to min or max.
// - Modulo form is opcode 4, extended 430, OE bit 21, record bit 31.
// - Saturating form is opcode 4, extended 494, same bit positions.
// - With OE set, update summary-overflow and overflow from the outcome.
// - Nor writes complement of the OR of both sources.
// - Nor is opcode 31, extended 124, record bit 31.
// - Register or writes OR of both sources.
// - Register or is opcode 31, extended 444.
// - Or-with-complement ORs first source with inverted second source.
// - Or-with-complement is opcode 31, extended 412.
// - Low or-immediate zero-extends immediate on the left, ORs with source.
// - Shifted or-immediate places immediate high with zeros below, ORs.
// - Low or-immediate with all fields zero is the preferred no-operation.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ns

module nma_alu (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Instruction and operand values from decode
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [31:0] sourceGpr,
  input wire logic [31:0] firstSourceGpr,
  input wire logic [31:0] secondSourceGpr,
  input wire logic xerSoIn,
  // Write-back to the register file and condition logic
  output nma_pkg::nma_wb_s wbOut,
  // Control register port
  input wire nma_pkg::nma_bus_s busIn,
  output logic [31:0] busRdata,
  // Interrupt
  output logic irq
);
  import nma_pkg::*;

  nma_state_s s_r;
  nma_state_s s_nxt;
  nma_op_e op;
  logic signed [31:0] prod;
  logic [31:0] nprod;
  logic [32:0] sum;
  logic ovf;
  logic [31:0] res;
  logic isNop;
  logic [2:0] ev;
  logic newSo;

  function automatic nma_op_e decodeOp(input logic [31:0] iw);
    logic [5:0] opc;
    logic [8:0] xo9;
    logic [9:0] xo10;
    opc = iw[31:POS_OPC];
    xo9 = iw[POS_OE-1:POS_XO];
    xo10 = iw[POS_OE:POS_XO];
    decodeOp = OP_NONE;
    if (opc == OPC_MAC && xo9 == XO_NMAC_MOD) begin
      decodeOp = OP_NMAC;
    end else if (opc == OPC_MAC && xo9 == XO_NMAC_SAT) begin
      decodeOp = OP_NMACS;
    end else if (opc == OPC_X && xo10 == XO_NOR) begin
      decodeOp = OP_NOR;
    end else if (opc == OPC_X && xo10 == XO_OR) begin
      decodeOp = OP_OR;
    end else if (opc == OPC_X && xo10 == XO_ORC) begin
      decodeOp = OP_ORC;
    end else if (opc == OPC_ORI) begin
      decodeOp = OP_ORI;
    end else if (opc == OPC_ORIS) begin
      decodeOp = OP_ORIS;
    end
  endfunction

  function automatic logic [3:0] condOf(input logic [31:0] v, input logic so);
    condOf = {v[31], ~v[31] && (v != 32'h00000000), v == 32'h00000000, so};
  endfunction

  assign op = decodeOp(instrWord);

  always_comb begin
    // signed low halfwords
    // Both halfwords are widened before the multiply so no tool forms a 16-bit product.
    prod = 32'($signed(firstSourceGpr[15:0])) * 32'($signed(secondSourceGpr[15:0]));
    nprod = 32'(-prod);
    sum = {nprod[31], nprod} + {sourceGpr[31], sourceGpr};
    ovf = (nprod[31] == sourceGpr[31]) && (sourceGpr[31] != sum[31]);
    isNop = (op == OP_ORI) && (instrWord[25:0] == 26'h0);
    res = 32'h00000000;
    case (op)
      OP_NMAC: res = sum[31:0];
      OP_NMACS: begin
        if (ovf) begin
          res = sourceGpr[31] ? SAT_MIN : SAT_MAX;
        end else begin
          res = sum[31:0];
        end
      end
      OP_NOR: res = ~(sourceGpr | secondSourceGpr);
      OP_OR: res = sourceGpr | secondSourceGpr;
      OP_ORC: res = sourceGpr | ~secondSourceGpr;
      OP_ORI: res = sourceGpr | {16'h0000, instrWord[15:0]};
      OP_ORIS: res = sourceGpr | {instrWord[15:0], 16'h0000};
      default: res = 32'h00000000;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    ev = 3'h0;
    newSo = xerSoIn;
    s_nxt.wb = '0;
    s_nxt.rdata = 32'h00000000;
    if (instrValid) begin
      ev[EV_ILLEGAL] = (op == OP_NONE);
      ev[EV_NOP] = isNop;
      if (op != OP_NONE && !(isNop && s_r.ctrl[CTRL_NOPSKIP])) begin
        s_nxt.wb.valid = 1'b1;
        s_nxt.wb.data = res;
        if (op == OP_NMAC || op == OP_NMACS) begin
          s_nxt.wb.dest = instrWord[25:POS_FLD6];
          ev[EV_OVF] = ovf;
          if (instrWord[POS_OE]) begin
            newSo = xerSoIn | ovf;
            s_nxt.wb.xerWe = 1'b1;
            s_nxt.wb.xerSo = newSo;
            s_nxt.wb.overflowFlag = ovf;
          end
        end else begin
          s_nxt.wb.dest = instrWord[20:POS_FLD11];
        end
        if (instrWord[POS_RC] && op != OP_ORI && op != OP_ORIS) begin
          s_nxt.wb.crWe = 1'b1;
          s_nxt.wb.conditionFieldZero = condOf(res, newSo);
        end
      end
    end
    if (busIn.rd) begin
      case (busIn.addr)
        OFS_CTRL: s_nxt.rdata = {31'h0, s_r.ctrl};
        OFS_STATUS: s_nxt.rdata = {29'h0, s_r.status};
        OFS_MASK: s_nxt.rdata = {29'h0, s_r.mask};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
    if (busIn.wr) begin
      case (busIn.addr)
        OFS_CTRL: s_nxt.ctrl = busIn.wdata[0:0];
        OFS_MASK: s_nxt.mask = busIn.wdata[2:0];
        default: s_nxt.ctrl = s_r.ctrl;
      endcase
    end
    // A read clears the sticky bits, but an event in the same cycle survives it.
    if (busIn.rd && busIn.addr == OFS_STATUS) begin
      s_nxt.status = ev;
    end else begin
      s_nxt.status = s_r.status | ev;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{wb: '0, ctrl: RST_CTRL, status: RST_STATUS, mask: RST_MASK,
        rdata: 32'h00000000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wbOut = s_r.wb;
  assign busRdata = s_r.rdata;
  assign irq = |(s_r.status & s_r.mask);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence nmacIssue;
    instrValid && op == OP_NMAC;
  endsequence

  sequence nmacsOverflow;
    instrValid && op == OP_NMACS && ovf;
  endsequence

  sequence statusClear;
    busIn.rd && busIn.addr == OFS_STATUS && !instrValid;
  endsequence

  mac_modulo_a: assert property (
    nmacIssue |=> wbOut.valid && wbOut.data ==
      32'($signed($past(sourceGpr)) - $signed($past(firstSourceGpr[15:0])) *
      $signed($past(secondSourceGpr[15:0]))))
    else $error("modulo accumulate result wrong");

  sat_clamp_a: assert property (
    nmacsOverflow |=> wbOut.data == ($past(sourceGpr[31]) ? SAT_MIN : SAT_MAX)
      && wbOut.valid)
    else $error("saturated result not clamped");

  sat_pass_a: assert property (
    instrValid && op == OP_NMACS && !ovf |=> wbOut.valid && wbOut.data ==
      32'($signed($past(sourceGpr)) - $signed($past(firstSourceGpr[15:0])) *
      $signed($past(secondSourceGpr[15:0]))))
    else $error("unsaturated sum altered");

  ovf_record_a: assert property (
    (instrValid && op == OP_NMACS && instrWord[POS_OE]) |=>
      wbOut.xerWe && wbOut.overflowFlag == $past(ovf)
      && (wbOut.xerSo == ($past(xerSoIn) | $past(ovf))))
    else $error("overflow bits not recorded");

  nor_result_a: assert property (
    instrValid && op == OP_NOR |=> wbOut.data ==
      ~($past(sourceGpr) | $past(secondSourceGpr)) &&
      wbOut.dest == $past(instrWord[20:16]))
    else $error("nor result wrong");

  orc_result_a: assert property (
    instrValid && op == OP_ORC |=> wbOut.data ==
      ($past(sourceGpr) | ~$past(secondSourceGpr)))
    else $error("or with complement wrong");

  oris_result_a: assert property (
    instrValid && op == OP_ORIS |=> wbOut.valid && !wbOut.crWe &&
      wbOut.data[15:0] == $past(sourceGpr[15:0]))
    else $error("shifted immediate or wrong");

  cr_record_a: assert property (
    instrValid && op == OP_OR && instrWord[POS_RC] |=> wbOut.crWe &&
      wbOut.conditionFieldZero[1] == (wbOut.data == 32'h00000000))
    else $error("condition field not recorded");

  no_record_a: assert property (
    instrValid && !instrWord[POS_RC] |=> !wbOut.crWe)
    else $error("condition field written without record bit");

  nop_flag_a: assert property (
    instrValid && isNop ##1 statusClear |=> busRdata[EV_NOP])
    else $error("no-op event not latched");

  // Each family of instructions gets its own trigger so the checks stay short.
  sequence nmacAnyIssue;
    instrValid && (op == OP_NMAC || op == OP_NMACS);
  endsequence

  sequence logicIssue;
    instrValid && (op == OP_NOR || op == OP_OR || op == OP_ORC);
  endsequence

  sequence immIssue;
    instrValid && (op == OP_ORI || op == OP_ORIS);
  endsequence

  sequence nopSkipped;
    instrValid && isNop && s_r.ctrl[CTRL_NOPSKIP];
  endsequence

  // Decode checks read the raw fields, not the decoded op, so a wrong map shows up here.
  mod_decode_a: assert property (
    instrValid && instrWord[31:POS_OPC] == OPC_MAC &&
      instrWord[POS_OE-1:POS_XO] == XO_NMAC_MOD |=>
      wbOut.valid && wbOut.dest == $past(instrWord[25:POS_FLD6]))
    else $error("modulo accumulate not decoded");

  sat_decode_a: assert property (
    instrValid && instrWord[31:POS_OPC] == OPC_MAC &&
      instrWord[POS_OE-1:POS_XO] == XO_NMAC_SAT |=>
      wbOut.valid && wbOut.dest == $past(instrWord[25:POS_FLD6]))
    else $error("saturating accumulate not decoded");

  nor_decode_a: assert property (
    instrValid && instrWord[31:POS_OPC] == OPC_X &&
      instrWord[POS_OE:POS_XO] == XO_NOR |=>
      wbOut.valid && wbOut.crWe == $past(instrWord[POS_RC]))
    else $error("nor not decoded");

  or_decode_a: assert property (
    instrValid && instrWord[31:POS_OPC] == OPC_X &&
      instrWord[POS_OE:POS_XO] == XO_OR |=>
      wbOut.valid && wbOut.crWe == $past(instrWord[POS_RC]))
    else $error("register or not decoded");

  orc_decode_a: assert property (
    instrValid && instrWord[31:POS_OPC] == OPC_X &&
      instrWord[POS_OE:POS_XO] == XO_ORC |=>
      wbOut.valid && wbOut.crWe == $past(instrWord[POS_RC]))
    else $error("or with complement not decoded");

  mod_ovf_a: assert property (
    (instrValid && op == OP_NMAC && instrWord[POS_OE]) |=>
      wbOut.xerWe && wbOut.overflowFlag == $past(ovf)
      && (wbOut.xerSo == ($past(xerSoIn) | $past(ovf))))
    else $error("modulo overflow bits not recorded");

  no_oe_a: assert property (
    nmacAnyIssue ##0 !instrWord[POS_OE] |=> !wbOut.xerWe)
    else $error("overflow bits written without enable");

  or_result_a: assert property (
    instrValid && op == OP_OR |=> wbOut.valid && wbOut.dest == $past(instrWord[20:16])
      && wbOut.data == ($past(sourceGpr) | $past(secondSourceGpr)))
    else $error("register or result wrong");

  ori_result_a: assert property (
    instrValid && op == OP_ORI && !isNop |=> wbOut.valid && wbOut.data ==
      ($past(sourceGpr) | {16'h0000, $past(instrWord[15:0])}))
    else $error("low immediate or wrong");

  oris_high_a: assert property (
    instrValid && op == OP_ORIS |=> wbOut.data ==
      ($past(sourceGpr) | {$past(instrWord[15:0]), 16'h0000}))
    else $error("shifted immediate not placed high");

  nop_skip_a: assert property (
    nopSkipped |=> !wbOut.valid && s_r.status[EV_NOP])
    else $error("skipped no-op still written back");

  nop_write_a: assert property (
    instrValid && isNop && !s_r.ctrl[CTRL_NOPSKIP] |=> wbOut.valid &&
      wbOut.dest == 5'h00 && wbOut.data == $past(sourceGpr))
    else $error("preferred no-op not executed");

  cr_sign_a: assert property (
    logicIssue ##0 instrWord[POS_RC] |=> wbOut.crWe &&
      wbOut.conditionFieldZero[3] == wbOut.data[31] &&
      wbOut.conditionFieldZero[0] == $past(xerSoIn))
    else $error("condition sign or summary bit wrong");

  mac_record_a: assert property (
    nmacAnyIssue ##0 instrWord[POS_RC] |=> wbOut.crWe &&
      wbOut.conditionFieldZero[2] == (!wbOut.data[31] && wbOut.data != 32'h00000000))
    else $error("accumulate greater-than bit wrong");

  imm_no_record_a: assert property (
    immIssue |=> !wbOut.crWe)
    else $error("immediate or wrote condition field");

  illegal_quiet_a: assert property (
    instrValid && op == OP_NONE |=> !wbOut.valid && s_r.status[EV_ILLEGAL])
    else $error("undecoded word written back");

  // Sticky status must survive everything except a read of the status word.
  status_clear_a: assert property (
    statusClear |=> s_r.status == 3'h0)
    else $error("status not cleared by read");

  status_hold_a: assert property (
    s_r.status[EV_OVF] && !busIn.rd |=> s_r.status[EV_OVF])
    else $error("overflow status lost");

  rdata_idle_a: assert property (
    !busIn.rd |=> busRdata == 32'h00000000)
    else $error("read data shown without a read");

endmodule

// ---- rtl/nma_pkg.sv ----
// Constants, encodings and carrier types of the negative multiply-accumulate and OR datapath.
// Assumes big-endian instruction bit numbering: instruction bit 0 is instrWord[31].
package nma_pkg;

  // Primary opcodes.
  localparam logic [5:0] OPC_MAC = 6'h04;
  localparam logic [5:0] OPC_X = 6'h1f;
  localparam logic [5:0] OPC_ORI = 6'h18;
  localparam logic [5:0] OPC_ORIS = 6'h19;

  // Extended opcodes (9 bits after the overflow-enable bit, 10 bits for X forms).
  localparam logic [8:0] XO_NMAC_MOD = 9'h1ae;
  localparam logic [8:0] XO_NMAC_SAT = 9'h1ee;
  localparam logic [9:0] XO_NOR = 10'h07c;
  localparam logic [9:0] XO_OR = 10'h1bc;
  localparam logic [9:0] XO_ORC = 10'h19c;

  // Instruction field positions (little-endian index of each field).
  localparam int POS_OPC = 26;
  localparam int POS_FLD6 = 21;
  localparam int POS_FLD11 = 16;
  localparam int POS_OE = 10;
  localparam int POS_XO = 1;
  localparam int POS_RC = 0;

  // Saturation limits.
  localparam logic [31:0] SAT_MAX = 32'h7fffffff;
  localparam logic [31:0] SAT_MIN = 32'h80000000;

  // Register map of the control port.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [0:0] RST_CTRL = 1'h0;
  localparam logic [2:0] RST_STATUS = 3'h0;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam int CTRL_NOPSKIP = 0;
  localparam int EV_OVF = 0;
  localparam int EV_NOP = 1;
  localparam int EV_ILLEGAL = 2;

  typedef enum logic [7:0] {
    OP_NONE = 8'h01,
    OP_NMAC = 8'h02,
    OP_NMACS = 8'h04,
    OP_NOR = 8'h08,
    OP_OR = 8'h10,
    OP_ORC = 8'h20,
    OP_ORI = 8'h40,
    OP_ORIS = 8'h80
  } nma_op_e;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [31:0] data;
    logic crWe;
    logic [3:0] conditionFieldZero;
    logic xerWe;
    logic xerSo;
    logic overflowFlag;
  } nma_wb_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } nma_bus_s;

  typedef struct packed {
    nma_wb_s wb;
    logic [0:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] rdata;
  } nma_state_s;

endpackage

// ---- testbench/nma_core_model.sv ----
// Far-side model of the core: holds summary overflow and forwards fresh write-back.
// Assumes write-back arrives registered, one cycle after the instruction is taken.
`timescale 1ns/1ns
module nma_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Write-back from the datapath
  input wire nma_pkg::nma_wb_s wbIn,
  // Summary overflow seen by the next instruction
  output logic xerSoOut
);
  import nma_pkg::*;
  logic soHeld_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) soHeld_r <= 1'b0;
    else if (wbIn.xerWe) soHeld_r <= wbIn.xerSo;
  end
  // Forwarding lets overflow-enabled operations run back to back without a stall.
  assign xerSoOut = wbIn.xerWe ? wbIn.xerSo : soHeld_r;
endmodule

// ---- testbench/nma_alu_tb.sv ----
// Self-checking bench for the multiply-accumulate and OR datapath.
// Assumes write-back one cycle after issue and the core model for summary overflow.
`timescale 1ns/1ns
module nma_alu_tb;
  import nma_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic instrValid = 1'b0;
  logic [31:0] instrWord = 32'h0;
  logic [31:0] sourceGpr = 32'h0;
  logic [31:0] firstSourceGpr = 32'h0;
  logic [31:0] secondSourceGpr = 32'h0;
  logic xerSoIn;
  nma_wb_s wbOut;
  nma_wb_s expWb;
  nma_wb_s seenWb;
  nma_bus_s busIn = '0;
  logic [31:0] busRdata;
  logic irq;
  logic skipOn = 1'b0;
  int err_total = 0;
  int checks = 0;

  always #5 core_clk = ~core_clk;

  nma_alu u_nma_alu (.core_clk(core_clk), .reset_n(reset_n), .instrValid(instrValid),
    .instrWord(instrWord), .sourceGpr(sourceGpr), .firstSourceGpr(firstSourceGpr),
    .secondSourceGpr(secondSourceGpr), .xerSoIn(xerSoIn), .wbOut(wbOut), .busIn(busIn),
    .busRdata(busRdata), .irq(irq));
  nma_core_model u_nma_core_model (.core_clk(core_clk), .reset_n(reset_n), .wbIn(wbOut),
    .xerSoOut(xerSoIn));

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic nma_wb_s model(logic [31:0] w, s, a, b, logic so);
    nma_wb_s e;
    logic [31:0] np;
    logic [31:0] r;
    logic [32:0] t;
    logic ov;
    logic rc;
    e = '0;
    r = 32'h0;
    rc = w[0];
    np = -(32'($signed(a[15:0])) * 32'($signed(b[15:0])));
    t = {np[31], np} + {s[31], s};
    ov = (np[31] == s[31]) && (s[31] != t[31]);
    e.valid = 1'b1;
    e.dest = w[20:16];
    case (w[31:26])
      OPC_MAC: begin
        e.dest = w[25:21];
        r = t[31:0];
        if (w[9:1] != XO_NMAC_MOD && w[9:1] != XO_NMAC_SAT) e.valid = 1'b0;
        else if (w[9:1] == XO_NMAC_SAT && ov) r = s[31] ? SAT_MIN : SAT_MAX;
        e.xerWe = w[10];
        e.overflowFlag = ov;
        so = so | (w[10] & ov);
        e.xerSo = so;
      end
      OPC_X: begin
        if (w[10:1] == XO_NOR) r = ~(s | b);
        else if (w[10:1] == XO_OR) r = s | b;
        else if (w[10:1] == XO_ORC) r = s | ~b;
        else e.valid = 1'b0;
      end
      OPC_ORI: begin
        r = s | {16'h0, w[15:0]};
        rc = 1'b0;
        if (w == {OPC_ORI, 26'h0} && skipOn) e.valid = 1'b0;
      end
      OPC_ORIS: begin
        r = s | {w[15:0], 16'h0};
        rc = 1'b0;
      end
      default: e.valid = 1'b0;
    endcase
    e.data = r;
    e.crWe = rc;
    e.conditionFieldZero = {$signed(r) < 0, $signed(r) > 0, r == 32'h0, so};
    return e.valid ? e : '0;
  endfunction

  // The expectation is formed from the very values the datapath samples at the edge.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) expWb <= '0;
    else expWb <= instrValid ? model(instrWord, sourceGpr, firstSourceGpr,
      secondSourceGpr, xerSoIn) : '0;
  end

  // Flag values are only meaningful while their write enable is high.
  always @(negedge core_clk) begin
    if (reset_n) begin
      seenWb = wbOut;
      if (!expWb.xerWe) {seenWb.xerSo, seenWb.overflowFlag} = {expWb.xerSo, expWb.overflowFlag};
      if (!expWb.crWe) seenWb.conditionFieldZero = expWb.conditionFieldZero;
      check("wb", 64'(seenWb), 64'(expWb));
    end
  end

  task automatic issue(input logic [31:0] w, s, a, b);
    instrValid <= 1'b1;
    instrWord <= w;
    sourceGpr <= s;
    firstSourceGpr <= a;
    secondSourceGpr <= b;
    @(posedge core_clk);
  endtask

  task automatic idle();
    instrValid <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic bus(input logic isWr, input logic [7:0] addr, input logic [31:0] d);
    busIn <= '{wr: isWr, rd: !isWr, addr: addr, wdata: d};
    @(posedge core_clk);
    busIn <= '0;
    @(negedge core_clk);
    if (!isWr) check("rdata", 64'(busRdata), 64'(d));
    @(posedge core_clk);
  endtask

  task automatic irqIs(input logic exp);
    @(negedge core_clk);
    check("irq", 64'(irq), 64'(exp));
    @(posedge core_clk);
  endtask

  function automatic logic [31:0] mac(logic [8:0] xo, logic oe, logic rc);
    return {OPC_MAC, 5'd3, 5'd4, 5'd5, oe, xo, rc};
  endfunction

  function automatic logic [31:0] xf(logic [9:0] xo, logic rc);
    return {OPC_X, 5'd6, 5'd7, 5'd8, xo, rc};
  endfunction

  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #20000;
    err_total++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(1'b0, OFS_CTRL, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    bus(1'b1, OFS_MASK, 32'h7);
    bus(1'b0, OFS_MASK, 32'h7);
    issue(mac(XO_NMAC_MOD, 1'b0, 1'b1), 32'h10, 32'hffff0003, 32'h00010004);
    issue(mac(XO_NMAC_MOD, 1'b0, 1'b0), 32'h100, 32'h0000fffe, 32'h00000003);
    issue(mac(XO_NMAC_MOD, 1'b1, 1'b1), 32'h80000000, 32'h1, 32'h1);
    issue(mac(XO_NMAC_SAT, 1'b1, 1'b1), 32'h80000000, 32'h1, 32'h1);
    issue(mac(XO_NMAC_SAT, 1'b0, 1'b1), 32'h7fffffff, 32'h8000, 32'h1);
    issue(mac(XO_NMAC_SAT, 1'b1, 1'b0), 32'h5, 32'h7fff, 32'h7fff);
    issue(xf(XO_NOR, 1'b1), 32'h0f0f0000, 32'h0, 32'h000000f0);
    issue(xf(XO_OR, 1'b0), 32'h80000001, 32'h0, 32'h00000100);
    issue(xf(XO_OR, 1'b1), 32'h0, 32'h0, 32'h0);
    issue(xf(XO_ORC, 1'b1), 32'h00000001, 32'h0, 32'hffff0000);
    issue({OPC_ORI, 10'h21, 16'h8001}, 32'h12340000, 32'h0, 32'h0);
    issue({OPC_ORIS, 10'h21, 16'h8001}, 32'h00001234, 32'h0, 32'h0);
    issue({OPC_ORI, 26'h0}, 32'h0, 32'h0, 32'h0);
    issue({OPC_X, 15'h0, 10'h3ff, 1'b1}, 32'h0, 32'h0, 32'h0);
    idle();
    irqIs(1'b1);
    bus(1'b0, OFS_STATUS, 32'h7);
    irqIs(1'b0);
    bus(1'b1, OFS_MASK, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1);
    skipOn <= 1'b1;
    idle();
    issue({OPC_ORI, 26'h0}, 32'h0, 32'h0, 32'h0);
    instrValid <= 1'b0;
    bus(1'b0, OFS_STATUS, 32'h2);
    irqIs(1'b0);
    bus(1'b0, OFS_STATUS, 32'h0);
    close_out();
  end
endmodule
